//--- link_recovery_defines.vh
`ifndef LINK_RECOVERY_DEFINES_VH
`define LINK_RECOVERY_DEFINES_VH

// ********************************************
// Character coding on the user streams
// ********************************************
// 9-bit N-Char: bit 8 set marks a control char, low bits 0 = EOP, 1 = EEP
`define NCHAR_W        9
`define NCHAR_CTRL_BIT 8
`define NCHAR_EOP      9'h100
`define NCHAR_EEP      9'h101
`define ADDR_W         8

// ********************************************
// Error cause vector bit positions
// ********************************************
`define ERR_W          5
`define ERR_PARITY     0
`define ERR_DISCONNECT 1
`define ERR_ESCAPE     2
`define ERR_CHAR_SEQ   3
`define ERR_CREDIT     4

// ********************************************
// Timing
// ********************************************
// Disconnect hold time in ns, converted to ref_clk cycles
`define DISC_HOLD_NS     12800
`define REF_CLK_MHZ      25
`define DISC_HOLD_CYCLES ((`DISC_HOLD_NS * `REF_CLK_MHZ + 999) / 1000)
`define DISC_CNT_W       9

// FIFO defaults
`define FIFO_DEPTH     8
`define FIFO_PTR_W     3

`endif

//--- link_fifo.v
`timescale 1ns/1ps
`include "link_recovery_defines.vh"

// ********************************************
// Synchronous FIFO with valid/ready on both sides
// ********************************************
module link_fifo #(
  parameter WIDTH = `NCHAR_W,
  parameter DEPTH = `FIFO_DEPTH,
  parameter PTR_W = `FIFO_PTR_W
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W:0]   count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[PTR_W:0]);
  assign out_valid = (count != {(PTR_W+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @* begin
    out_data = mem[rd_ptr];
  end

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      count  <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

//--- link_error_recovery.v
`timescale 1ns/1ps
`include "link_recovery_defines.vh"

module link_error_recovery #(
  parameter IS_SWITCH    = 1'b0,
  parameter DISC_CYCLES  = `DISC_HOLD_CYCLES,
  parameter FIFO_DEPTH   = `FIFO_DEPTH,
  parameter FIFO_PTR_W   = `FIFO_PTR_W
) (
  input  wire                ref_clk,
  input  wire                rst,
  input  wire                link_enable,
  input  wire                link_clk,
  input  wire [`ERR_W-1:0]   err_cause,
  input  wire                link_up,
  input  wire [`NCHAR_W-1:0] rx_char,
  input  wire                rx_char_valid,
  input  wire                rx_header_err,
  input  wire                rx_addr_known,
  output wire                rx_out_valid,
  output wire [`NCHAR_W-1:0] rx_out_data,
  input  wire                rx_out_ready,
  output reg                 rx_eep_flag,
  output reg                 rx_addr_err,
  output reg                 rx_header_flag,
  input  wire [`NCHAR_W-1:0] tx_app_data,
  input  wire                tx_app_valid,
  output wire                tx_app_ready,
  input  wire                tx_addr_known,
  output reg                 tx_addr_err,
  output reg  [`NCHAR_W-1:0] tx_link_data,
  output reg                 tx_link_valid,
  input  wire                tx_link_ready,
  output reg                 link_disconnect,
  output reg                 link_error,
  output reg                 link_error_status
);

  // ********************************************
  // Input synchronisers
  // ********************************************
  localparam SYNC_W = `ERR_W + 6 + `NCHAR_W;
  // Enable idles high so a release from reset shows no false disconnect
  localparam [SYNC_W-1:0] SYNC_RST = {{(SYNC_W-`ERR_W-2){1'b0}}, 1'b1, {(`ERR_W+1){1'b0}}};
  wire [SYNC_W-1:0] async_in;
  wire [`NCHAR_W-1:0] rx_char_s;
  wire              hdr_err_s;
  wire              addr_known_s;
  reg  [SYNC_W-1:0] sync_a;
  reg  [SYNC_W-1:0] sync_b;
  reg               link_clk_prev;
  wire [`ERR_W-1:0] err_s;
  wire              enable_s;
  wire              up_s;
  wire              lclk_s;
  wire              lclk_rise;
  reg               err_prev;

  // Character and its qualifiers travel through the same two stages as link_clk
  assign async_in  = {rx_addr_known, rx_header_err, rx_char, link_clk, link_up, link_enable, rx_char_valid, err_cause};
  assign rx_char_s    = sync_b[`ERR_W+4 +: `NCHAR_W];
  assign hdr_err_s    = sync_b[`ERR_W+4+`NCHAR_W];
  assign addr_known_s = sync_b[`ERR_W+5+`NCHAR_W];
  assign err_s     = sync_b[`ERR_W-1:0];
  assign enable_s  = sync_b[`ERR_W+1];
  assign up_s      = sync_b[`ERR_W+2];
  assign lclk_s    = sync_b[`ERR_W+3];
  assign lclk_rise = lclk_s & ~link_clk_prev;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_a        <= SYNC_RST;
      sync_b        <= SYNC_RST;
      link_clk_prev <= 1'b0;
      err_prev      <= 1'b0;
    end else begin
      sync_a        <= async_in;
      sync_b        <= sync_a;
      link_clk_prev <= lclk_s;
      err_prev      <= |err_s;
    end
  end

  // Any of the five causes gives one error event
  wire err_any  = |err_s;
  wire err_rise = err_any & ~err_prev;

  // ********************************************
  // Recovery state machine
  // ********************************************
  localparam ST_RUN   = 4'b0001;
  localparam ST_FLUSH = 4'b0010;
  localparam ST_HOLD  = 4'b0100;
  localparam ST_WAIT  = 4'b1000;

  reg  [3:0]             state;
  reg  [3:0]             next_state;
  reg  [`DISC_CNT_W-1:0] hold_cnt;
  reg                    eep_done;
  wire                   rx_in_ready;
  reg                    last_was_end;
  reg                    tx_spill;

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (err_rise) begin
          next_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (eep_done) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (hold_cnt == DISC_CYCLES[`DISC_CNT_W-1:0] - 1'b1) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (enable_s & ~err_any) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state             <= ST_RUN;
      hold_cnt          <= {`DISC_CNT_W{1'b0}};
      link_disconnect   <= 1'b0;
      link_error        <= 1'b0;
      link_error_status <= 1'b0;
    end else begin
      state           <= next_state;
      hold_cnt        <= (state == ST_HOLD) ? hold_cnt + 1'b1 : {`DISC_CNT_W{1'b0}};
      // Disconnect only this link while recovering or disabled
      link_disconnect <= (next_state != ST_RUN) | ~enable_s;
      link_error      <= err_rise & ~IS_SWITCH;
      if (err_rise & IS_SWITCH) begin
        link_error_status <= 1'b1;
      end else if (up_s) begin
        link_error_status <= 1'b0;
      end
    end
  end

  // ********************************************
  // Receive path
  // ********************************************
  reg                 spill_rx;
  reg                 rx_first;
  reg                 lclk_valid;
  reg [`NCHAR_W-1:0]  fifo_in_data;
  reg                 fifo_in_valid;
  wire                rx_is_end;
  wire                rx_take;
  wire                insert_eep;

  assign rx_is_end  = rx_char_s[`NCHAR_CTRL_BIT];
  assign rx_take    = lclk_rise & lclk_valid & (state == ST_RUN);
  assign insert_eep = (state == ST_FLUSH) & ~last_was_end;

  always @* begin
    eep_done = (state == ST_FLUSH) & (last_was_end | rx_in_ready);
  end

  always @* begin
    lclk_valid = sync_b[`ERR_W];
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_was_end   <= 1'b1;
      spill_rx       <= 1'b0;
      rx_first       <= 1'b1;
      fifo_in_data   <= {`NCHAR_W{1'b0}};
      fifo_in_valid  <= 1'b0;
      rx_eep_flag    <= 1'b0;
      rx_addr_err    <= 1'b0;
      rx_header_flag <= 1'b0;
    end else begin
      fifo_in_valid  <= 1'b0;
      rx_eep_flag    <= 1'b0;
      rx_addr_err    <= 1'b0;
      rx_header_flag <= 1'b0;
      if (insert_eep & rx_in_ready) begin
        fifo_in_data  <= `NCHAR_EEP;
        fifo_in_valid <= 1'b1;
        last_was_end  <= 1'b1;
        // Corrupt null/FCT or escape pair: EEP ends the packet, the next char starts a new one and nothing is spilled
        spill_rx      <= 1'b0;
        rx_first      <= 1'b1;
      end else if (state == ST_FLUSH) begin
        // Error inside a discarded packet spills the following packet; right after an end marker nothing spills
        spill_rx      <= ~rx_first;
        rx_first      <= 1'b1;
      end else if (rx_take & rx_in_ready) begin
        if (rx_first & (hdr_err_s | (IS_SWITCH & ~addr_known_s))) begin
          spill_rx       <= ~rx_is_end;
          rx_header_flag <= hdr_err_s & ~IS_SWITCH;
        end else if (spill_rx) begin
          spill_rx <= ~rx_is_end;
        end else begin
          fifo_in_data  <= rx_char_s;
          fifo_in_valid <= 1'b1;
          last_was_end  <= rx_is_end;
          rx_eep_flag   <= ~IS_SWITCH & (rx_char_s == `NCHAR_EEP);
          rx_addr_err   <= ~IS_SWITCH & rx_first & ~addr_known_s;
        end
        rx_first <= rx_is_end;
      end
    end
  end

  link_fifo #(
    .WIDTH (`NCHAR_W),
    .DEPTH (FIFO_DEPTH),
    .PTR_W (FIFO_PTR_W)
  ) rx_fifo (
    .clk       (ref_clk),
    .rst       (rst),
    .in_data   (fifo_in_data),
    .in_valid  (fifo_in_valid),
    .in_ready  (rx_in_ready),
    .out_data  (rx_out_data),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready)
  );

  // ********************************************
  // Transmit path
  // ********************************************
  reg  tx_first;
  reg  tx_addr_spill;
  wire tx_is_end = tx_app_data[`NCHAR_CTRL_BIT];
  wire tx_drop   = tx_spill | tx_addr_spill | (tx_first & ~tx_addr_known);

  assign tx_app_ready = tx_drop ? 1'b1 : ((state == ST_RUN) & (~tx_link_valid | tx_link_ready));

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_spill      <= 1'b0;
      tx_addr_spill <= 1'b0;
      tx_first      <= 1'b1;
      tx_addr_err   <= 1'b0;
      tx_link_data  <= {`NCHAR_W{1'b0}};
      tx_link_valid <= 1'b0;
    end else begin
      tx_addr_err <= 1'b0;
      if (tx_link_valid & tx_link_ready) begin
        tx_link_valid <= 1'b0;
      end
      if (err_rise & ~tx_first) begin
        tx_spill      <= 1'b1;
        tx_link_valid <= 1'b0;
      end else if (tx_app_valid & tx_app_ready) begin
        if (tx_first & ~tx_addr_known & ~tx_spill) begin
          tx_addr_spill <= ~tx_is_end;
          tx_addr_err   <= 1'b1;
        end else if (tx_spill | tx_addr_spill) begin
          tx_spill      <= tx_spill & ~tx_is_end;
          tx_addr_spill <= tx_addr_spill & ~tx_is_end;
        end else begin
          tx_link_data  <= tx_app_data;
          tx_link_valid <= 1'b1;
        end
        tx_first <= tx_is_end;
      end
    end
  end

endmodule

//--- link_error_recovery_chk.sv
`timescale 1ns/1ps
`include "link_recovery_defines.vh"
module link_error_recovery_chk #(
  parameter DISC_CYCLES = 4
) (
  input wire                ref_clk,
  input wire                rst,
  input wire                link_enable,
  input wire [`ERR_W-1:0]   err_cause,
  input wire                rx_out_valid,
  input wire [`NCHAR_W-1:0] rx_out_data,
  input wire                rx_out_ready,
  input wire                rx_eep_flag,
  input wire                tx_addr_err,
  input wire                link_disconnect,
  input wire                link_error
);
  // ****
  // Properties
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence err_rise;
    $rose(|err_cause) && !link_disconnect;
  endsequence
  sequence hold_disc;
    link_disconnect[*4];
  endsequence
  chk_err_report: assert property (err_rise |-> ##[2:6] link_error)
    else $error("link error not reported");
  chk_err_disc: assert property (err_rise |-> ##[1:6] link_disconnect)
    else $error("link not disconnected on error");
  chk_disc_hold: assert property ($rose(link_disconnect) |-> hold_disc)
    else $error("disconnect too short");
  chk_err_pulse: assert property (link_error |=> !link_error)
    else $error("link error not a pulse");
  chk_disable_disc: assert property (!link_enable[*6] |-> link_disconnect)
    else $error("disabled link not disconnected");
  chk_eep_pulse: assert property (rx_eep_flag |=> !rx_eep_flag)
    else $error("eep flag not a pulse");
  chk_txerr_pulse: assert property (tx_addr_err |=> !tx_addr_err)
    else $error("tx address flag not a pulse");
  chk_rx_hold: assert property (rx_out_valid && !rx_out_ready |=> rx_out_valid && $stable(rx_out_data))
    else $error("rx output changed while stalled");
endmodule

bind link_error_recovery link_error_recovery_chk #(.DISC_CYCLES(DISC_CYCLES)) link_error_recovery_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .link_enable(link_enable), .err_cause(err_cause),
  .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data), .rx_out_ready(rx_out_ready),
  .rx_eep_flag(rx_eep_flag), .tx_addr_err(tx_addr_err), .link_disconnect(link_disconnect),
  .link_error(link_error));

//--- link_partner.sv
`timescale 1ns/1ps
module link_partner (
  input  wire       ref_clk,
  output reg        link_clk,
  output reg  [8:0] rx_char,
  output reg        rx_char_valid,
  output reg        rx_header_err,
  output reg        rx_addr_known,
  input  wire [8:0] tx_link_data,
  input  wire       tx_link_valid,
  output reg        tx_link_ready
);
  // ****
  // Far link end
  // ****
  reg       slow = 0;
  reg [8:0] got[$];
  initial begin
    link_clk = 0;
    rx_char = 0;
    rx_char_valid = 0;
    rx_header_err = 0;
    rx_addr_known = 1;
    tx_link_ready = 1;
  end
  always @(posedge ref_clk) begin
    tx_link_ready <= slow ? ~tx_link_ready : 1'b1;
    if (tx_link_valid === 1'b1 && tx_link_ready) got.push_back(tx_link_data);
  end
  // One char per 320 ns, clock still between chars
  task send(input [8:0] c, input k, input h);
    @(posedge ref_clk);
    rx_char <= c;
    rx_char_valid <= 1;
    rx_addr_known <= k;
    rx_header_err <= h;
    repeat (3) @(posedge ref_clk);
    link_clk <= 1;
    repeat (4) @(posedge ref_clk);
    link_clk <= 0;
    rx_char <= ~c;
    rx_char_valid <= 0;
  endtask
endmodule

//--- link_error_recovery_tb.sv
`timescale 1ns/1ps
`include "link_recovery_defines.vh"
module link_error_recovery_tb;
  // ****
  // Bench
  // ****
  reg        ref_clk, rst, link_enable, link_up, rx_out_ready, tx_app_valid, tx_addr_known;
  reg  [4:0] err_cause;
  reg  [8:0] tx_app_data;
  wire       link_clk, rx_char_valid, rx_header_err, rx_addr_known, rx_out_valid, rx_eep_flag;
  wire       rx_addr_err, rx_header_flag, tx_app_ready, tx_addr_err, tx_link_valid, tx_link_ready;
  wire       link_disconnect, link_error, link_error_status;
  wire [8:0] rx_char, rx_out_data, tx_link_data;
  integer    n_fail = 0, num_checks = 0, n_lerr = 0, n_eep = 0, n_aerr = 0, n_txerr = 0, n_hdr = 0, i, b, e0, a0;

  link_error_recovery #(.DISC_CYCLES(4)) link_error_recovery_inst (.ref_clk, .rst, .link_enable, .link_clk,
    .err_cause, .link_up, .rx_char, .rx_char_valid, .rx_header_err, .rx_addr_known, .rx_out_valid,
    .rx_out_data, .rx_out_ready, .rx_eep_flag, .rx_addr_err, .rx_header_flag, .tx_app_data, .tx_app_valid,
    .tx_app_ready, .tx_addr_known, .tx_addr_err, .tx_link_data, .tx_link_valid, .tx_link_ready,
    .link_disconnect, .link_error, .link_error_status);
  link_partner link_partner_inst (.ref_clk, .link_clk, .rx_char, .rx_char_valid, .rx_header_err,
    .rx_addr_known, .tx_link_data, .tx_link_valid, .tx_link_ready);

  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    link_up <= ~link_disconnect;
    if (link_error === 1'b1) n_lerr++;
    if (rx_eep_flag === 1'b1) n_eep++;
    if (rx_addr_err === 1'b1) n_aerr++;
    if (tx_addr_err === 1'b1) n_txerr++;
    if (rx_header_flag === 1'b1) n_hdr++;
  end

  task chk(input string nm, input [31:0] e, input [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task pop(input [8:0] e);
    @(negedge ref_clk);
    for (i = 0; i < 60 && rx_out_valid !== 1'b1; i++) @(negedge ref_clk);
    chk("rx_out_data", e, rx_out_data);
    @(posedge ref_clk) rx_out_ready <= 1;
    @(posedge ref_clk) rx_out_ready <= 0;
  endtask
  task empty;
    repeat (30) @(negedge ref_clk);
    chk("rx_out_valid", 0, rx_out_valid);
  endtask
  task settle;
    repeat (6) @(negedge ref_clk);
    for (i = 0; i < 60 && link_disconnect !== 1'b0; i++) @(negedge ref_clk);
    chk("link_disconnect", 0, link_disconnect);
    repeat (4) @(negedge ref_clk);
  endtask
  task err(input integer n);
    @(posedge ref_clk) err_cause <= 5'h01 << n;
    repeat (3) @(posedge ref_clk);
    err_cause <= 5'h00;
    settle;
  endtask
  task tx(input [8:0] c, input k);
    @(posedge ref_clk);
    tx_app_data <= c;
    tx_addr_known <= k;
    tx_app_valid <= 1;
    @(negedge ref_clk);
    for (i = 0; i < 400 && tx_app_ready !== 1'b1; i++) @(negedge ref_clk);
    @(posedge ref_clk) tx_app_valid <= 0;
  endtask

  task t_reset_err;
    err(0);
    chk("link_error count", 1, n_lerr);
    chk("link_error_status", 0, link_error_status);
    empty;
  endtask
  task t_header;
    e0 = n_hdr;
    link_partner_inst.send(9'h0FF, 1, 1);
    link_partner_inst.send(9'h061, 1, 0);
    link_partner_inst.send(`NCHAR_EOP, 1, 0);
    link_partner_inst.send(9'h062, 1, 0);
    link_partner_inst.send(`NCHAR_EOP, 1, 0);
    pop(9'h062);
    pop(`NCHAR_EOP);
    empty;
    chk("header flags", e0 + 1, n_hdr);
  endtask
  task t_mid_err;
    for (b = 0; b < 5; b++) begin
      link_partner_inst.send(9'h010 + b, 1, 0);
      link_partner_inst.send(9'h0A5, 1, 0);
      err(b);
      pop(9'h010 + b);
      pop(9'h0A5);
      pop(`NCHAR_EEP);
      chk("link_error count", b + 2, n_lerr);
    end
  endtask
  task t_eop_err;
    link_partner_inst.send(9'h020, 1, 0);
    link_partner_inst.send(`NCHAR_EOP, 1, 0);
    err(3);
    pop(9'h020);
    pop(`NCHAR_EOP);
    empty;
  endtask
  task t_eep_addr;
    e0 = n_eep;
    a0 = n_aerr;
    link_partner_inst.send(9'h030, 0, 0);
    link_partner_inst.send(`NCHAR_EEP, 1, 0);
    pop(9'h030);
    pop(`NCHAR_EEP);
    chk("eep flags", e0 + 1, n_eep);
    chk("addr flags", a0 + 1, n_aerr);
  endtask
  task t_enable;
    @(posedge ref_clk) link_enable <= 0;
    repeat (8) @(negedge ref_clk);
    chk("link_disconnect", 1, link_disconnect);
    @(posedge ref_clk) link_enable <= 1;
    settle;
  endtask
  task t_tx;
    link_partner_inst.slow = 1;
    tx(9'h002, 1);
    tx(9'h011, 1);
    tx(`NCHAR_EOP, 1);
    tx(9'h009, 0);
    tx(9'h022, 1);
    tx(`NCHAR_EOP, 1);
    tx(9'h003, 1);
    tx(`NCHAR_EOP, 1);
    repeat (20) @(negedge ref_clk);
    chk("tx spill flags", 1, n_txerr);
    chk("tx count", 5, link_partner_inst.got.size());
    link_partner_inst.slow = 0;
    tx(9'h005, 1);
    tx(9'h044, 1);
    repeat (6) @(negedge ref_clk);
    err(4);
    tx(9'h055, 1);
    tx(`NCHAR_EOP, 1);
    tx(9'h006, 1);
    tx(`NCHAR_EOP, 1);
    repeat (20) @(negedge ref_clk);
    chk("tx count", 9, link_partner_inst.got.size());
    chk("tx after spill", 9'h006, link_partner_inst.got[7]);
  endtask
  task t_full;
    for (b = 0; b < 10; b++) link_partner_inst.send(9'h040 + b, 1, 0);
    for (b = 0; b < 8; b++) pop(9'h040 + b);
    empty;
  endtask

  task conclude;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    rst = 1;
    link_enable = 1;
    link_up = 0;
    rx_out_ready = 0;
    tx_app_valid = 0;
    tx_addr_known = 1;
    err_cause = 0;
    tx_app_data = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    repeat (4) @(negedge ref_clk);
    t_reset_err;
    t_mid_err;
    t_eop_err;
    t_eep_addr;
    t_header;
    t_enable;
    t_tx;
    t_full;
    conclude;
  end
  initial begin
    #400000;
    n_fail++;
    conclude;
  end
endmodule
